// ===== pdr_defs.svh
// offsets, field positions and reset values for the port direction block
`ifndef PDR_DEFS_SVH
`define PDR_DEFS_SVH
`define PDR_NUM_PORTS 7
`define PDR_NUM_SEG_PORTS 4
`define PDR_OFF_DATA0 12'h000
`define PDR_OFF_DIR0 12'h004
`define PDR_OFF_SEGDIS0 12'h040
`define PDR_OFF_P7 12'h050
`define PDR_OFF_P7DIR 12'h054
`define PDR_OFF_PERIPH 12'h058
`define PDR_OFF_PIN 12'h05c
`define PDR_P7_MUL_A 0
`define PDR_P7_MUL_B 1
`define PDR_P7_LO 2
`define PDR_P7_HI 4
`define PDR_RST_BYTE 8'h00
`endif

// ===== pdr_pins.sv
// board model: drives port pins where the device floats them
`timescale 1ns/1ps
module pdr_pins (
	pin_out,
	pin_oe,
	board,
	p7_out,
	p7_oe,
	board7,
	pin_in,
	p7_in
);
	input wire logic [55:0] pin_out;
	input wire logic [55:0] pin_oe;
	input wire logic [55:0] board;
	input wire logic [4:2] p7_out;
	input wire logic [4:2] p7_oe;
	input wire logic [4:0] board7;
	output logic [55:0] pin_in;
	output logic [4:0] p7_in;
	// floating pins follow the board, driven ones the device
	assign pin_in = (pin_out & pin_oe) | (board & ~pin_oe);
	assign p7_in = {(p7_out & p7_oe) | (board7[4:2] & ~p7_oe), board7[1:0]};
endmodule

// ===== pdr_pkg.sv
// types shared by the port direction block
package pdr_pkg;
	typedef logic [7:0] pdr_byte_t;
	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} pdr_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pdr_apb_rsp_t;
	typedef struct packed {
		pdr_byte_t [6:0] latch;
		pdr_byte_t [6:0] dir;
		pdr_byte_t [3:0] segdis;
		logic [4:2] p7_latch;
		logic [4:2] p7_dir;
		logic [31:0] prdata;
		logic pslverr;
	} pdr_state_t;
	typedef struct packed {
		logic realtime_port_out_0;
		logic realtime_port_out_1;
		logic timer_x_out_a;
		logic timer_x_out_b;
		logic timer_four_out;
		logic timer_three_out;
		logic timer_two_or_clock_out;
	} pdr_periph_t;
endpackage

// ===== pdr_port.sv
// gpio direction, latch and readback logic behind an apb slave
// Functional notes
// - each direction-controlled pin has its own direction bit.
// - direction bit zero always makes the pin an input.
// - lower four ports drive only when direction and segment-disable are both one.
// - upper ports and three last-port pins drive when direction is one.
// - reading an output pin returns the port latch.
// - selected peripheral output makes reads return the peripheral value.
// - input pins stay undriven; writes update only the latch.
// - multiplier-shared input pins read one while multiplier in use.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "pdr_defs.svh"
module pdr_port (
	input wire logic CLK,
	input wire logic RESET,
	input wire pdr_pkg::pdr_apb_req_t APB_REQ,
	output pdr_pkg::pdr_apb_rsp_t APB_RSP,
	input wire logic [55:0] PIN_IN,
	input wire logic [4:0] P7_PIN_IN,
	output logic [55:0] PIN_OUT,
	output logic [55:0] PIN_OE,
	output logic [4:2] P7_PIN_OUT,
	output logic [4:2] P7_PIN_OE,
	input wire logic MULTIPLIER_ACTIVE,
	input wire pdr_pkg::pdr_periph_t PERIPH_OUT,
	input wire logic [6:0] PERIPH_SEL
);
	import pdr_pkg::*;

	pdr_state_t st;
	pdr_state_t next_st;
	logic [55:0] oe;
	logic [55:0] ovr_en;
	logic [55:0] ovr_val;
	logic [55:0] rd_pin;
	logic [7:0] p7_rd;
	logic [11:0] off;
	logic wr;
	logic rd;
	logic hit;

	// peripheral pin mapping: p5.0, p5.1, p6.5, p6.3, p6.6, p6.7, p4.7 (assumed positions)
	always_comb begin
		ovr_en = '0;
		ovr_val = '0;
		ovr_en[40] = PERIPH_SEL[0];
		ovr_val[40] = PERIPH_OUT.realtime_port_out_0;
		ovr_en[41] = PERIPH_SEL[1];
		ovr_val[41] = PERIPH_OUT.realtime_port_out_1;
		ovr_en[53] = PERIPH_SEL[2];
		ovr_val[53] = PERIPH_OUT.timer_x_out_a;
		ovr_en[51] = PERIPH_SEL[3];
		ovr_val[51] = PERIPH_OUT.timer_x_out_b;
		ovr_en[54] = PERIPH_SEL[4];
		ovr_val[54] = PERIPH_OUT.timer_four_out;
		ovr_en[55] = PERIPH_SEL[5];
		ovr_val[55] = PERIPH_OUT.timer_three_out;
		ovr_en[39] = PERIPH_SEL[6];
		ovr_val[39] = PERIPH_OUT.timer_two_or_clock_out;
	end

	// direction decode and per-pin readback
	always_comb begin
		for (int p = 0; p < `PDR_NUM_PORTS; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (p < `PDR_NUM_SEG_PORTS) begin
					oe[p*8+b] = st.dir[p][b] & st.segdis[p][b];
				end else begin
					oe[p*8+b] = st.dir[p][b];
				end
				if (ovr_en[p*8+b]) begin
					rd_pin[p*8+b] = ovr_val[p*8+b];
				end else if (oe[p*8+b]) begin
					rd_pin[p*8+b] = st.latch[p][b];
				end else begin
					rd_pin[p*8+b] = PIN_IN[p*8+b];
				end
			end
		end
	end

	always_comb begin
		p7_rd = 8'h00;
		p7_rd[4:0] = P7_PIN_IN;
		for (int b = `PDR_P7_LO; b <= `PDR_P7_HI; b++) begin
			if (st.p7_dir[b]) begin
				p7_rd[b] = st.p7_latch[b];
			end
		end
		if (MULTIPLIER_ACTIVE) begin
			p7_rd[`PDR_P7_MUL_A] = 1'b1;
			p7_rd[`PDR_P7_MUL_B] = 1'b1;
		end
	end

	// pins drive only where enabled; latch never reaches an input pin
	always_comb begin
		for (int i = 0; i < 56; i++) begin
			PIN_OE[i] = oe[i] | (ovr_en[i] & oe[i]);
			PIN_OUT[i] = ovr_en[i] ? ovr_val[i] : st.latch[i/8][i%8];
		end
		P7_PIN_OE = st.p7_dir;
		P7_PIN_OUT = st.p7_latch;
	end

	assign off = APB_REQ.paddr[11:0];
	assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
	assign rd = APB_REQ.psel & ~APB_REQ.penable & ~APB_REQ.pwrite;

	// zero-wait slave: read data captured in setup, pready always high
	always_comb begin
		next_st = st;
		hit = 1'b0;
		if (APB_REQ.psel & ~APB_REQ.penable) begin
			next_st.prdata = 32'h00000000;
			next_st.pslverr = 1'b0;
		end
		for (int p = 0; p < `PDR_NUM_PORTS; p++) begin
			if (off == `PDR_OFF_DATA0 + 12'(p*8)) begin
				hit = 1'b1;
				if (wr) begin
					next_st.latch[p] = APB_REQ.pwdata[7:0];
				end
				if (rd) begin
					next_st.prdata = {24'h000000, rd_pin[p*8 +: 8]};
				end
			end
			if (off == `PDR_OFF_DIR0 + 12'(p*8)) begin
				hit = 1'b1;
				if (wr) begin
					next_st.dir[p] = APB_REQ.pwdata[7:0];
				end
				if (rd) begin
					next_st.prdata = {24'h000000, st.dir[p]};
				end
			end
		end
		for (int p = 0; p < `PDR_NUM_SEG_PORTS; p++) begin
			if (off == `PDR_OFF_SEGDIS0 + 12'(p*4)) begin
				hit = 1'b1;
				if (wr) begin
					next_st.segdis[p] = APB_REQ.pwdata[7:0];
				end
				if (rd) begin
					next_st.prdata = {24'h000000, st.segdis[p]};
				end
			end
		end
		if (off == `PDR_OFF_P7) begin
			hit = 1'b1;
			if (wr) begin
				next_st.p7_latch = APB_REQ.pwdata[4:2];
			end
			if (rd) begin
				next_st.prdata = {24'h000000, p7_rd};
			end
		end
		if (off == `PDR_OFF_P7DIR) begin
			hit = 1'b1;
			if (wr) begin
				next_st.p7_dir = APB_REQ.pwdata[4:2];
			end
			if (rd) begin
				next_st.prdata = {27'h0000000, st.p7_dir, 2'b00};
			end
		end
		if (off == `PDR_OFF_PIN || off == `PDR_OFF_PERIPH) begin
			hit = 1'b1;
			if (rd) begin
				next_st.prdata = (off == `PDR_OFF_PIN) ? {27'h0000000, P7_PIN_IN} : {25'h0000000, PERIPH_SEL};
			end
		end
		// unmapped: slverr, reads zero
		if (APB_REQ.psel & ~APB_REQ.penable & ~hit) begin
			next_st.pslverr = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RESET) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign APB_RSP.prdata = st.prdata;
	assign APB_RSP.pready = 1'b1;
	assign APB_RSP.pslverr = st.pslverr & APB_REQ.psel & APB_REQ.penable;

	property p_dir_zero_input;
		@(posedge CLK) disable iff (RESET) (st.dir[4][0] == 1'b0) |-> (PIN_OE[32] == 1'b0);
	endproperty
	a_dir_zero_input: assert property (p_dir_zero_input) else $error("pin driven with direction zero");

	property p_seg_needs_both;
		@(posedge CLK) disable iff (RESET) PIN_OE[0] |-> (st.dir[0][0] && st.segdis[0][0]);
	endproperty
	a_seg_needs_both: assert property (p_seg_needs_both) else $error("segment pin driven without both bits");

	property p_upper_out;
		@(posedge CLK) disable iff (RESET) wr && off == `PDR_OFF_DIR0 + 12'h020 && APB_REQ.pwdata[0] |=> PIN_OE[32];
	endproperty
	a_upper_out: assert property (p_upper_out) else $error("upper pin not driven after direction set");

	property p_latch_read;
		@(posedge CLK) disable iff (RESET) rd && off == `PDR_OFF_DATA0 && oe[0] && !ovr_en[0] |=> APB_RSP.prdata[0] == $past(st.latch[0][0]);
	endproperty
	a_latch_read: assert property (p_latch_read) else $error("output read not from latch");

	property p_periph_read;
		@(posedge CLK) disable iff (RESET) rd && off == `PDR_OFF_DATA0 + 12'h028 && PERIPH_SEL[0] |=> APB_RSP.prdata[0] == $past(PERIPH_OUT.realtime_port_out_0);
	endproperty
	a_periph_read: assert property (p_periph_read) else $error("peripheral value not read");

	property p_input_float;
		@(posedge CLK) disable iff (RESET) wr && off == `PDR_OFF_DATA0 && !st.dir[0][0] |=> !PIN_OE[0];
	endproperty
	a_input_float: assert property (p_input_float) else $error("write drove input pin");

	property p_mul_one;
		@(posedge CLK) disable iff (RESET) rd && off == `PDR_OFF_P7 && MULTIPLIER_ACTIVE |=> APB_RSP.prdata[1:0] == 2'b11;
	endproperty
	a_mul_one: assert property (p_mul_one) else $error("multiplier pins not read as one");

	property p_reset_dir;
		@(posedge CLK) $past(RESET) |-> (PIN_OE == 56'h0 && P7_PIN_OE == 3'b000);
	endproperty
	a_reset_dir: assert property (p_reset_dir) else $error("pins driven after reset");
endmodule

// ===== testbench.sv
// self-checking bench for the port direction block
`timescale 1ns/1ps
module testbench;
	import pdr_pkg::*;
	logic CLK = 0, RESET = 1, mul = 0;
	pdr_apb_req_t req = '0;
	pdr_apb_rsp_t rsp;
	pdr_periph_t per = '0;
	logic [6:0] sel = 0;
	logic [55:0] pin_in, pin_out, pin_oe, board;
	logic [4:0] p7_in;
	logic [4:2] p7_out, p7_oe;
	logic [32:0] q[$];
	logic [32:0] e;
	logic [7:0] d, l, s, b;
	logic [4:0] b7, t;
	int miscompares = 0, checks_done = 0, seed = 32'h28d3;
	always #50 CLK = ~CLK;
	pdr_port dut_u (.CLK(CLK), .RESET(RESET), .APB_REQ(req), .APB_RSP(rsp), .PIN_IN(pin_in), .P7_PIN_IN(p7_in),
		.PIN_OUT(pin_out), .PIN_OE(pin_oe), .P7_PIN_OUT(p7_out), .P7_PIN_OE(p7_oe), .MULTIPLIER_ACTIVE(mul),
		.PERIPH_OUT(per), .PERIPH_SEL(sel));
	pdr_pins pins_u (.pin_out(pin_out), .pin_oe(pin_oe), .board(board), .p7_out(p7_out), .p7_oe(p7_oe),
		.board7(b7), .pin_in(pin_in), .p7_in(p7_in));
	task end_of_test;
		if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task cmp(input logic [55:0] x, input logic [55:0] a);
		@(negedge CLK);
		checks_done++;
		if (a !== x) begin
			miscompares++;
			$display("[ERR] %0t exp %h got %h", $time, x, a);
		end
		@(posedge CLK);
	endtask
	// hold the request until pready is seen high, then release
	task apb(input logic w, input logic [31:0] a, input logic [31:0] v);
		req.paddr <= a;
		req.pwrite <= w;
		req.pwdata <= v;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge CLK);
		req.penable <= 1'b1;
		@(posedge CLK);
		while (rsp.pready !== 1'b1) @(posedge CLK);
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge CLK);
	endtask
	task rd(input logic [31:0] a, input logic [32:0] x);
		q.push_back(x);
		apb(1'b0, a, 32'h0);
	endtask
	always @(posedge CLK) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			checks_done++;
			if ({rsp.pslverr, rsp.prdata} !== e) begin
				miscompares++;
				$display("[ERR] %0t exp %h got %h", $time, e, {rsp.pslverr, rsp.prdata});
			end
		end
	end
	initial begin
		#2000000;
		miscompares++;
		end_of_test;
	end
	initial begin
		board <= 56'({$random(seed), $random(seed)});
		b7 <= 5'($random(seed));
		repeat (10) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		cmp(56'h0, pin_oe);
		for (int p = 0; p < 7; p++) begin
			rd(8 * p + 4, 33'h0);
			d = 8'($random(seed));
			l = 8'($random(seed));
			s = p < 4 ? 8'($random(seed)) : 8'hff;
			b = board[p * 8 +: 8];
			apb(1'b1, 8 * p + 4, {24'h0, d});
			apb(1'b1, 8 * p, {24'h0, l});
			if (p < 4) apb(1'b1, 32'h40 + 4 * p, {24'h0, s});
			cmp(56'(d & s), 56'(pin_oe[p * 8 +: 8]));
			cmp(56'(l & d & s), 56'(pin_out[p * 8 +: 8] & d & s));
			rd(8 * p, {25'h0, (l & d & s) | (b & ~(d & s))});
			rd(8 * p + 4, {25'h0, d});
			apb(1'b1, 8 * p + 4, 32'hff);
			if (p < 4) apb(1'b1, 32'h40 + 4 * p, 32'hff);
			cmp(56'(l), 56'(pin_out[p * 8 +: 8]));
			cmp(56'hff, 56'(pin_oe[p * 8 +: 8]));
			rd(8 * p, {25'h0, l});
		end
		// mid-run reset must drop every driver again
		RESET <= 1'b1;
		repeat (2) @(posedge CLK);
		RESET <= 1'b0;
		@(posedge CLK);
		cmp(56'h0, pin_oe);
		rd(32'h4, 33'h0);
		d = 8'($random(seed));
		l = 8'($random(seed));
		t = {(l[4:2] & d[4:2]) | (b7[4:2] & ~d[4:2]), b7[1:0]};
		apb(1'b1, 32'h54, {24'h0, d});
		apb(1'b1, 32'h50, {24'h0, l});
		cmp(56'(d[4:2]), 56'(p7_oe));
		cmp(56'(l[4:2]), 56'(p7_out));
		rd(32'h50, {28'h0, t});
		mul <= 1'b1;
		rd(32'h50, {28'h0, t[4:2], 2'b11});
		mul <= 1'b0;
		rd(32'h50, {28'h0, t});
		apb(1'b1, 32'h2c, 32'h1);
		apb(1'b1, 32'h28, 32'h0);
		per <= '1;
		sel <= 7'h01;
		rd(32'h28, {25'h0, board[47:41], 1'b1});
		rd(32'hff0, {1'b1, 32'h0});
		end_of_test;
	end
endmodule
